/* hdl/tod_ctrl.sv */
`timescale 1ns/1ns
`include "tod_defines.svh"
module tod_ctrl
  import tod_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic query_done,
  input wire logic pulse_per_second,
  input wire logic ext_pulse_per_second,
  input wire logic [15:0] tune_mv,
  input wire logic tune_valid,
  input wire logic freq_locked,
  input wire logic [3:0] lock_code,
  input wire logic [31:0] fine_phase_ps,
  output logic atomic_power_en,
  output logic lock_alarm_output,
  output logic [31:0] synth_correction,
  output logic discipline_active,
  output logic [15:0] mode
);
  pulse_if own_p();
  pulse_if ext_p();
  assign own_p.raw = pulse_per_second;
  assign ext_p.raw = ext_pulse_per_second;
  edge_sync u_own (
    .clk(clk),
    .reset_n(reset_n),
    .p(own_p)
  );
  edge_sync u_ext (
    .clk(clk),
    .reset_n(reset_n),
    .p(ext_p)
  );

  typedef struct packed {
    logic [31:0] tod;
    logic [31:0] tod_reply;
    logic query_pend;
    logic query_done;
    logic [15:0] mode;
    logic [31:0] sleep_s;
    logic [31:0] wake_s;
    logic [31:0] sec_cnt;
    power_state_t pw;
    logic [31:0] steer;
    logic [31:0] applied_steer;
    logic [15:0] tune_mv;
    logic [31:0] tune_corr;
    logic [31:0] latched;
    phase_state_t ph;
    logic [31:0] ph_cnt;
    logic [3:0] ph_div;
    logic [31:0] phase;
    logic [31:0] rdata;
  } ctrl_state_t;
  ctrl_state_t q, d;

  logic locked, awake, lowpwr;
  logic [3:0] status;
  logic signed [31:0] tune_delta;
  logic signed [49:0] tune_prod;

  always_comb begin
    lowpwr = q.mode[`MODE_LOWPWR_BIT];
    awake = q.pw != pw_sleep;
    locked = awake && freq_locked;
    status = !awake ? `STATUS_ASLEEP : (freq_locked ? `STATUS_LOCKED : lock_code);
    tune_delta = $signed({16'h0000, q.tune_mv}) - $signed({16'h0000, `TUNE_ZERO_MV});
    // result in units of 1e-12 fractional frequency
    tune_prod = tune_delta * $signed({14'h0000, `TUNE_PPT_PER_MV});
  end

  always_comb begin
    d = q;
    d.query_done = 1'b0;
    d.rdata = 32'h0000_0000;

    if (own_p.rise) begin
      d.tod = q.tod + 32'h0000_0001;
      if (q.query_pend) begin
        d.tod_reply = q.tod + 32'h0000_0001;
        d.query_pend = 1'b0;
        d.query_done = 1'b1;
      end
    end

    // once-per-second tuning update, only while awake and locked
    if (own_p.rise && q.mode[`MODE_ANALOG_BIT] && tune_valid && locked) begin
      d.tune_mv = tune_mv;
    end
    if (own_p.rise && q.mode[`MODE_ANALOG_BIT] && locked) begin
      d.tune_corr = tune_prod[31:0];
    end

    // steering reaches the synthesizer only under lock
    if (locked) begin
      d.applied_steer = q.steer
        + (q.mode[`MODE_ANALOG_BIT] ? q.tune_corr : 32'h0000_0000);
    end

    // power sequencer
    case (q.pw)
      pw_normal: begin
        d.sec_cnt = 32'h0000_0000;
        if (lowpwr) begin
          d.pw = pw_acquire;
        end
      end
      pw_acquire: begin
        d.sec_cnt = 32'h0000_0000;
        if (!lowpwr) begin
          d.pw = pw_normal;
        end else if (freq_locked) begin
          d.pw = pw_wake;
        end
      end
      pw_wake: begin
        if (!lowpwr) begin
          d.pw = pw_normal;
        end else if (own_p.rise && freq_locked) begin
          d.sec_cnt = q.sec_cnt + 32'h0000_0001;
          if (q.sec_cnt + 32'h0000_0001 >= q.wake_s) begin
            d.pw = pw_sleep;
            d.sec_cnt = 32'h0000_0000;
          end
        end
      end
      pw_sleep: begin
        if (!lowpwr) begin
          d.pw = pw_normal;
        end else if (own_p.rise) begin
          d.sec_cnt = q.sec_cnt + 32'h0000_0001;
          if (q.sec_cnt + 32'h0000_0001 >= q.sleep_s) begin
            d.pw = pw_acquire;
            d.sec_cnt = 32'h0000_0000;
          end
        end
      end
      default: d.pw = pw_normal;
    endcase

    // phase meter: counts 100 ns steps from the first edge to the other
    if (q.ph_div == 4'(`PHASE_DIV - 1)) begin
      d.ph_div = 4'h0;
    end else begin
      d.ph_div = q.ph_div + 4'h1;
    end
    case (q.ph)
      ph_idle: begin
        d.ph_cnt = 32'h0000_0000;
        d.ph_div = 4'h0;
        if (q.mode[`MODE_PHASE_BIT] && own_p.rise && ext_p.rise) begin
          // coincident edges are well inside the fine window
          d.phase = fine_phase_ps;
        end else if (q.mode[`MODE_PHASE_BIT] && own_p.rise) begin
          d.ph = ph_own_first;
        end else if (q.mode[`MODE_PHASE_BIT] && ext_p.rise) begin
          d.ph = ph_ext_first;
        end
      end
      ph_own_first, ph_ext_first: begin
        if (q.ph_div == 4'(`PHASE_DIV - 1)) begin
          d.ph_cnt = q.ph_cnt + 32'h0000_0001;
        end
        if ((q.ph == ph_own_first && ext_p.rise) || (q.ph == ph_ext_first && own_p.rise)) begin
          d.ph = ph_idle;
          if (q.ph_cnt < 32'(`FINE_WINDOW)) begin
            d.phase = fine_phase_ps;
          end else begin
            // sign follows external minus own
            d.phase = (q.ph == ph_own_first) ? q.ph_cnt : (32'h0000_0000 - q.ph_cnt);
          end
        end else if (q.ph_cnt >= 32'(`PHASE_LIMIT) || !q.mode[`MODE_PHASE_BIT]) begin
          d.ph = ph_idle;
        end
      end
      default: d.ph = ph_idle;
    endcase

    if (wr) begin
      case (addr)
        `A_MODE: begin
          d.mode = wdata[15:0];
          // the highest requested pulse option wins, the others clear
          if (wdata[`MODE_DISC_BIT]) begin
            d.mode = (wdata[15:0] & ~`MODE_PULSE_MASK) | (16'h0001 << `MODE_DISC_BIT);
          end else if (wdata[`MODE_SYNC_BIT]) begin
            d.mode = (wdata[15:0] & ~`MODE_PULSE_MASK) | (16'h0001 << `MODE_SYNC_BIT);
          end else if (wdata[`MODE_PHASE_BIT]) begin
            d.mode = (wdata[15:0] & ~`MODE_PULSE_MASK) | (16'h0001 << `MODE_PHASE_BIT);
          end
        end
        `A_TIME: d.tod = wdata;
        `A_TIME_ADJ: d.tod = (own_p.rise ? q.tod + 32'h0000_0001 : q.tod) + wdata;
        `A_TIME_QUERY: d.query_pend = 1'b1;
        `A_SLEEP: d.sleep_s = (wdata < `SLEEP_MIN_S) ? `SLEEP_MIN_S : wdata;
        `A_WAKE: d.wake_s = (wdata < `WAKE_MIN_S) ? `WAKE_MIN_S : wdata;
        `A_STEER: d.steer = wdata;
        `A_LATCH: begin
          if (status == `STATUS_LOCKED) begin
            d.latched = q.applied_steer;
          end
        end
        default: ;
      endcase
    end

    if (rd) begin
      case (addr)
        `A_MODE: d.rdata = {16'h0000, q.mode};
        `A_TIME: d.rdata = q.tod;
        `A_TIME_QUERY: d.rdata = q.tod_reply;
        `A_SLEEP: d.rdata = q.sleep_s;
        `A_WAKE: d.rdata = q.wake_s;
        `A_STEER: d.rdata = q.applied_steer;
        `A_STATUS: d.rdata = {28'h000_0000, status};
        `A_TUNE_MV: d.rdata = q.mode[`MODE_ANALOG_BIT] ? {16'h0000, q.tune_mv} : 32'h0000_0000;
        `A_TUNE_CORR: d.rdata = q.mode[`MODE_ANALOG_BIT] ? q.tune_corr : 32'h0000_0000;
        `A_PHASE: d.rdata = q.phase;
        `A_LATCHED: d.rdata = q.latched;
        default: d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.mode <= `MODE_RESET;
      q.sleep_s <= `SLEEP_MIN_S;
      q.wake_s <= `WAKE_MIN_S;
      q.pw <= pw_normal;
      q.ph <= ph_idle;
    end else begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign query_done = q.query_done;
  assign atomic_power_en = q.pw != pw_sleep;
  assign lock_alarm_output = !locked;
  assign synth_correction = q.applied_steer;
  // disciplining idles while asleep or unlocked; steering value is retained
  assign discipline_active = q.mode[`MODE_DISC_BIT] && locked;
  assign mode = q.mode;
endmodule // tod_ctrl

/* hdl/tod_defines.svh */
`ifndef TOD_DEFINES_SVH
`define TOD_DEFINES_SVH
`define CLK_HZ 10_000_000
`define PHASE_STEP_NS 100
`define PHASE_DIV (`PHASE_STEP_NS * `CLK_HZ / 1_000_000_000)
`define PHASE_HALF_RANGE_MS 500
`define PHASE_LIMIT (`PHASE_HALF_RANGE_MS * 1_000_000 / `PHASE_STEP_NS)
`define FINE_WINDOW_NS 1000
`define FINE_WINDOW (`FINE_WINDOW_NS / `PHASE_STEP_NS)
`define TUNE_ZERO_MV 16'h04E2
`define TUNE_PPT_PER_MV 18'h0_00B1
`define WAKE_MIN_S 32'h0000_000A
`define SLEEP_MIN_S 32'h0000_0708
`define STATUS_ASLEEP 4'h9
`define STATUS_LOCKED 4'h0
`define MODE_ANALOG_BIT 0
`define MODE_PHASE_BIT 2
`define MODE_SYNC_BIT 3
`define MODE_DISC_BIT 4
`define MODE_LOWPWR_BIT 5
`define MODE_PULSE_MASK 16'h001C
`define MODE_RESET 16'h0000
`define A_MODE 4'h0
`define A_TIME 4'h1
`define A_TIME_ADJ 4'h2
`define A_TIME_QUERY 4'h3
`define A_SLEEP 4'h4
`define A_WAKE 4'h5
`define A_STEER 4'h6
`define A_STATUS 4'h7
`define A_TUNE_MV 4'h8
`define A_TUNE_CORR 4'h9
`define A_PHASE 4'hA
`define A_LATCH 4'hB
`define A_LATCHED 4'hC
`endif

/* hdl/tod_pkg.sv */
package tod_pkg;
  typedef enum logic [1:0] {pw_sleep, pw_acquire, pw_wake, pw_normal} power_state_t;
  typedef enum logic [1:0] {ph_idle, ph_own_first, ph_ext_first} phase_state_t;
endpackage

/* hdl/pulse_if.sv */
`timescale 1ns/1ns
interface pulse_if;
  logic raw;
  logic level;
  logic rise;
  modport sync (input raw, output level, output rise);
  modport user (output raw, input level, input rise);
endinterface

/* hdl/edge_sync.sv */
`timescale 1ns/1ns
// three stage pin synchroniser; a change counts once stages two and three agree
module edge_sync (
  input wire logic clk,
  input wire logic reset_n,
  pulse_if.sync p
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic rise;
  } sync_state_t;
  sync_state_t q, d;
  always_comb begin
    d = q;
    d.s1 = p.raw;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.rise = 1'b0;
    if (q.s2 == q.s3 && q.s3 != q.level) begin
      d.level = q.s3;
      d.rise = q.s3;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign p.level = q.level;
  assign p.rise = q.rise;
endmodule // edge_sync

/* testbench/tod_ctrl_properties.sv */
`timescale 1ns/1ns
module tod_ctrl_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic query_done,
  input wire logic pulse_per_second,
  input wire logic freq_locked,
  input wire logic atomic_power_en,
  input wire logic lock_alarm_output,
  input wire logic [31:0] synth_correction,
  input wire logic [15:0] mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_alarm_asleep; !atomic_power_en |-> lock_alarm_output; endproperty
  a_alarm_asleep: assert property (p_alarm_asleep) else $error("alarm low asleep");
  // one cycle of slack, the alarm may be registered from the lock input
  property p_alarm_locked; !lock_alarm_output |-> freq_locked || $past(freq_locked); endproperty
  a_alarm_locked: assert property (p_alarm_locked) else $error("alarm low unlocked");
  property p_rdata_idle; !$past(rd) |-> rdata == 32'h0000_0000; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  property p_query_pulse; query_done |=> !query_done; endproperty
  a_query_pulse: assert property (p_query_pulse) else $error("query pulse long");
  property p_query_after_pulse; query_done |-> $past(pulse_per_second, 3); endproperty
  a_query_after_pulse: assert property (p_query_after_pulse) else $error("early reply");
  property p_mode_onehot; $onehot0(mode[4:2]); endproperty
  a_mode_onehot: assert property (p_mode_onehot) else $error("pulse options clash");
  property p_mode_write;
    wr && addr == 4'h0 && $onehot0(wdata[4:2]) |=> mode[5:2] == $past(wdata[5:2]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode not taken");
  property p_steer_held;
    !freq_locked && !$past(freq_locked) |-> $stable(synth_correction);
  endproperty
  a_steer_held: assert property (p_steer_held) else $error("steer moved unlocked");
  c_query: cover property (query_done);
  c_sleep: cover property ($fell(atomic_power_en));
  c_wake: cover property ($rose(atomic_power_en));
endmodule // tod_ctrl_checker
bind tod_ctrl tod_ctrl_checker chk_u (.*);

/* testbench/atomic_model.sv */
`timescale 1ns/1ns
// atomic section: own second pulse and lock acquisition, seconds shortened
module atomic_model #(
  parameter int PERIOD = 12,
  parameter int LOCK_SECS = 3
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic power_en,
  output logic pps,
  output logic locked,
  output logic [3:0] code
);
  int cyc;
  int secs;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cyc <= 0;
      secs <= 0;
    end else begin
      cyc <= (cyc == PERIOD - 1) ? 0 : cyc + 1;
      if (!power_en) secs <= 0;
      else if (cyc == 0 && secs < LOCK_SECS) secs <= secs + 1;
    end
  end
  // pulse starts half a second late so the count is zero for a while
  assign pps = cyc >= PERIOD / 2;
  assign locked = power_en && secs >= LOCK_SECS;
  assign code = locked ? 4'h0 : 4'(8 - secs);
endmodule // atomic_model

/* testbench/testbench.sv */
`timescale 1ns/1ns
module testbench;
  logic clk = 0, reset_n = 0, wr = 0, rd = 0;
  logic [3:0] addr = '0, code;
  logic [31:0] wdata = '0, rdata, synth;
  logic [15:0] tune_mv = 16'h04E2, mode;
  logic pps, locked, power_en, alarm, qdone, disc;
  int error_cnt = 0, n_checks = 0;
  tod_ctrl dut_u (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .query_done(qdone), .pulse_per_second(pps), .ext_pulse_per_second(pps),
    .tune_mv(tune_mv), .tune_valid(1'b1), .freq_locked(locked), .lock_code(code),
    .fine_phase_ps(32'h0000_01C2), .atomic_power_en(power_en), .lock_alarm_output(alarm),
    .synth_correction(synth), .discipline_active(disc), .mode(mode));
  atomic_model #(.PERIOD(12), .LOCK_SECS(3)) atom_u (.clk(clk), .reset_n(reset_n),
    .power_en(power_en), .pps(pps), .locked(locked), .code(code));
  initial forever #50 clk = ~clk;
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrr(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input string what, input logic [3:0] a, input logic [31:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    @(negedge clk) check(what, exp, rdata);
    @(posedge clk);
  endtask
  // leaves us well clear of the next pulse so the target second is certain
  task automatic wait_pulse(input int k);
    repeat (k) @(posedge pps);
    repeat (6) @(posedge clk);
  endtask
  task automatic query(input logic [31:0] exp);
    int n = 0;
    wrr(4'h3, '0);
    while (qdone !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    check("query wait", 1, n < 40);
    rdc("time reply", 4'h3, exp);
  endtask
  task automatic t_reset();
    rdc("time", 4'h1, '0);
    rdc("mode", 4'h0, '0);
    rdc("sleep", 4'h4, 32'h0000_0708);
    rdc("wake", 4'h5, 32'h0000_000A);
    rdc("unmapped", 4'hF, '0);
    wrr(4'h4, 32'h0000_0005);
    rdc("sleep", 4'h4, 32'h0000_0708);
    wrr(4'h5, 32'h0000_0009);
    rdc("wake", 4'h5, 32'h0000_000A);
    $display("reset test done");
  endtask
  task automatic t_time();
    wait_pulse(1);
    wrr(4'h1, 32'hFFFF_FFFF);
    query(32'h0000_0000);
    wrr(4'h2, 32'hFFFF_FFFB);
    query(32'hFFFF_FFFC);
    $display("time test done");
  endtask
  task automatic t_mode();
    logic [15:0] req[4] = '{16'h0014, 16'h000C, 16'h001C, 16'h0004};
    logic [15:0] want[4] = '{16'h0010, 16'h0008, 16'h0010, 16'h0004};
    for (int i = 0; i < 4; i++) begin
      wrr(4'h0, {16'h0000, req[i]});
      rdc("mode", 4'h0, {16'h0000, want[i]});
    end
    wait_pulse(2);
    rdc("phase", 4'hA, 32'h0000_01C2);
    wrr(4'h0, 32'h0000_0001);
    tune_mv <= 16'h0546;
    wait_pulse(2);
    rdc("tune mv", 4'h8, 32'h0000_0546);
    rdc("tune corr", 4'h9, 32'h0000_4524);
    tune_mv <= 16'h047E;
    wait_pulse(2);
    rdc("tune corr", 4'h9, 32'hFFFF_BADC);
    $display("mode test done");
  endtask
  task automatic t_lowpower();
    int n = 0;
    int m = 0;
    // latch saves the applied steering: written steer plus the last tuning correction
    wrr(4'h6, 32'h0000_0100);
    rdc("steer", 4'h6, 32'hFFFF_BBDC);
    wrr(4'hB, 32'h0000_1234);
    rdc("latched", 4'hC, 32'hFFFF_BBDC);
    wrr(4'h0, 32'h0000_0021);
    while (power_en !== 1'b0 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    check("sleep entry", 1, n < 1000);
    @(posedge clk);
    check("alarm", 1, alarm);
    rdc("status", 4'h7, 32'h0000_0009);
    wrr(4'hB, 32'h0000_5678);
    rdc("latched", 4'hC, 32'hFFFF_BBDC);
    n = 0;
    while (power_en !== 1'b1 && n < 30000) begin
      @(posedge clk);
      n++;
    end
    check("sleep span", 1, n > 21560 && n < 21620);
    while (locked !== 1'b1 && n < 30000) begin
      @(posedge clk);
      n++;
    end
    while (power_en !== 1'b0 && m < 1000) begin
      @(posedge clk);
      m++;
      if (m == 2) check("alarm", 0, alarm);
    end
    check("wake span", 1, m > 108 && m < 132);
    $display("low power test done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_time();
    t_mode();
    t_lowpower();
    report_and_stop();
  end
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end
endmodule // testbench
